// ===== design/receive_filter_and_status.sv
// receive acceptance filter, packet status and error tallies with axi4-lite registers
//
// Function
// - save-errored bit keeps crc/alignment errored frames
// - reject under 64 bytes; runts need 8
// - broadcast accepted only with broadcast bit
// - group address accepted via hash when enabled
// - unicast needs station match unless all-unicast
// - acceptance conditions are ORed together
// - listen-only checks, never stores, counts missed
// - offset 0c writes config, reads status
// - status written at frame end when stored
// - status cleared at each new frame
// - intact only when crc/align/overrun/missed clear
// - crc flag also on alignment; counts crc
// - alignment flag on dribble plus crc fail
// - fifo overflow sets overrun, aborts frame
// - missed on no buffers or listen-only
// - group flag: 0 station, 1 group
// - receiver-off flag follows listen-only mode
// - deferring flag follows carrier or collision
// - alignment-only error code never occurs
// - registers are eight bits wide
// - ring page registers hold bits 15-8
// - top six crc bits index 64-bit hash
// - station compare byte by byte, received order
`timescale 1ns/1ns
module receive_filter_and_status
   import rx_filter_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        frame_start,
   input  wire logic        dest_byte_valid,
   input  wire logic [7:0]  dest_byte,
   input  wire logic [5:0]  dest_hash_index,
   input  wire logic        frame_end,
   input  wire logic [15:0] frame_length,
   input  wire logic        crc_bad,
   input  wire logic [2:0]  dribble_bits,
   input  wire logic        fifo_overflow,
   input  wire logic        no_rx_buffers,
   input  wire logic        carrier_or_collision,
   output      logic        frame_abort,
   output      logic        frame_store,
   output      logic        status_write,
   output      logic [7:0]  status_byte,
   output      logic        crc_error_inc,
   output      logic        align_error_inc,
   output      logic        missed_packet_inc
);
   logic [7:0]  cfg_reg;
   logic [7:0]  status_reg;
   logic [47:0] station_reg;
   logic [63:0] hash_reg;
   logic [7:0]  ring_first_page_reg;
   logic [7:0]  ring_last_page_reg;
   logic [7:0]  ring_boundary_page_reg;
   logic [2:0]  byte_idx_reg;
   logic        uni_match_reg;
   logic        bcast_reg;
   logic        group_reg;
   logic        hash_hit_reg;
   logic        in_frame_reg;
   logic        overrun_reg;
   logic [7:0]  crc_tally_reg;
   logic [7:0]  align_tally_reg;
   logic [7:0]  missed_tally_reg;
   logic        frame_abort_reg;
   logic        store_reg;
   logic        status_wr_reg;
   logic [7:0]  status_byte_reg;
   logic [2:0]  inc_reg;
   logic        car_s1_reg;
   logic        car_s2_reg;
   // axi slave: aw and w taken together, one transaction at a time
   logic        wr_go;
   logic        rd_go;
   logic [7:0]  rd_word;
   logic        rd_hit;
   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   function automatic logic wr_sel(input logic [7:0] a, input logic [7:0] want);
      wr_sel = (a == want);
   endfunction : wr_sel
   // config register is byte wide; only lane 0 of its word is live
   logic wr_lane0;
   logic wr_cfg;
   logic wr_ring;
   assign wr_lane0 = wr_go & s_axi_wstrb[0];
   assign wr_cfg   = wr_lane0 & wr_sel(s_axi_awaddr, ADDR_RX_CFG_STATUS);
   assign wr_ring  = wr_go & wr_sel(s_axi_awaddr, ADDR_RING_PAGES);
   logic aw_known;
   assign aw_known = wr_sel(s_axi_awaddr, ADDR_RX_CFG_STATUS)
                   | wr_sel(s_axi_awaddr, ADDR_STATION_LO) | wr_sel(s_axi_awaddr, ADDR_STATION_HI)
                   | wr_sel(s_axi_awaddr, ADDR_HASH_LO) | wr_sel(s_axi_awaddr, ADDR_HASH_HI)
                   | wr_sel(s_axi_awaddr, ADDR_RING_PAGES) | wr_sel(s_axi_awaddr, ADDR_TALLIES);
   // read side: 0c returns status, never config
   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 8'h00;
      case (s_axi_araddr)
         ADDR_RX_CFG_STATUS : rd_word = status_reg;
         ADDR_RING_PAGES    : rd_word = ring_boundary_page_reg;
         ADDR_TALLIES       : rd_word = missed_tally_reg;
         ADDR_STATION_LO, ADDR_STATION_HI, ADDR_HASH_LO, ADDR_HASH_HI : rd_word = 8'h00;
         default            : rd_hit = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= aw_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_word};
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // station and hash bytes: each write strobe lane writes its own byte, except lanes 2-3 at station hi, which are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg     <= CFG_RESET;
         station_reg <= 48'h0000_0000_0000;
         hash_reg    <= 64'h0000_0000_0000_0000;
      end else begin
         if (wr_cfg)
            cfg_reg <= s_axi_wdata[7:0] & CFG_MASK;
         for (int b = 0; b < 4; b++) begin
            if (wr_go && s_axi_wstrb[b]) begin
               if (wr_sel(s_axi_awaddr, ADDR_STATION_LO))
                  station_reg[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
               if (wr_sel(s_axi_awaddr, ADDR_STATION_HI) && b < 2)
                  station_reg[32 + (b % 2)*8 +: 8] <= s_axi_wdata[b*8 +: 8];
               if (wr_sel(s_axi_awaddr, ADDR_HASH_LO))
                  hash_reg[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
               if (wr_sel(s_axi_awaddr, ADDR_HASH_HI))
                  hash_reg[32 + b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            end
         end
      end
   end
   // page registers only carry address bits 15..8
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ring_first_page_reg    <= 8'h00;
         ring_last_page_reg     <= 8'h00;
         ring_boundary_page_reg <= 8'h00;
      end else if (wr_ring) begin
         if (s_axi_wstrb[0]) ring_first_page_reg    <= s_axi_wdata[7:0];
         if (s_axi_wstrb[1]) ring_last_page_reg     <= s_axi_wdata[15:8];
         if (s_axi_wstrb[2]) ring_boundary_page_reg <= s_axi_wdata[23:16];
      end
   end
   // address tracking while destination bytes arrive
   logic [7:0] station_byte;
   assign station_byte = station_reg[byte_idx_reg*8 +: 8];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         byte_idx_reg  <= 3'd0;
         uni_match_reg <= 1'b0;
         bcast_reg     <= 1'b0;
         group_reg     <= 1'b0;
         hash_hit_reg  <= 1'b0;
         in_frame_reg  <= 1'b0;
         overrun_reg   <= 1'b0;
      end else if (frame_start) begin
         byte_idx_reg  <= 3'd0;
         uni_match_reg <= 1'b1;
         bcast_reg     <= 1'b1;
         group_reg     <= 1'b0;
         hash_hit_reg  <= 1'b0;
         in_frame_reg  <= 1'b1;
         // an overflow in the start cycle wins over the clear
         overrun_reg   <= fifo_overflow;
      end else begin
         if (dest_byte_valid && byte_idx_reg < 3'd6) begin
            byte_idx_reg  <= byte_idx_reg + 3'd1;
            uni_match_reg <= uni_match_reg & (dest_byte == station_byte);
            bcast_reg     <= bcast_reg & (dest_byte == 8'hff);
            if (byte_idx_reg == 3'd0)
               group_reg <= dest_byte[0];
            if (byte_idx_reg == 3'd5)
               hash_hit_reg <= hash_reg[dest_hash_index];
         end
         if (fifo_overflow && in_frame_reg)
            overrun_reg <= 1'b1;
         if (frame_end)
            in_frame_reg <= 1'b0;
      end
   end
   // acceptance decision at frame end
   logic       is_bcast;
   logic       is_mcast;
   logic       addr_ok;
   logic       len_ok;
   logic       align_err;
   logic       crc_err;
   logic       rx_err;
   logic       err_ok;
   logic       recognised;
   logic       missed;
   logic       keep;
   logic [7:0] status_next;
   assign is_bcast   = group_reg & bcast_reg;
   assign is_mcast   = group_reg & ~bcast_reg;
   assign addr_ok    = (is_bcast & cfg_reg[CFG_BCAST])
                     | (is_mcast & cfg_reg[CFG_GROUP] & hash_hit_reg)
                     | (~group_reg & (cfg_reg[CFG_ALL_UNI] | uni_match_reg));
   assign len_ok     = (frame_length >= MIN_FRAME_BYTES)
                     | (cfg_reg[CFG_RUNT] & (frame_length >= MIN_RUNT_BYTES));
   // dribble of six bits or more with bad crc is an alignment error
   assign align_err  = crc_bad & (dribble_bits >= DRIBBLE_LIMIT);
   assign crc_err    = crc_bad;
   assign rx_err     = crc_err | align_err;
   assign err_ok     = ~rx_err | cfg_reg[CFG_SAVE_ERR];
   assign recognised = addr_ok & len_ok & err_ok & ~overrun_reg;
   assign missed     = recognised & (no_rx_buffers | cfg_reg[CFG_LISTEN]);
   assign keep       = recognised & ~missed;
   always_comb begin
      status_next              = STATUS_RESET;
      status_next[ST_CRC]      = crc_err;
      status_next[ST_ALIGN]    = align_err;
      status_next[ST_OVERRUN]  = overrun_reg;
      status_next[ST_MISSED]   = missed;
      status_next[ST_GROUP]    = group_reg;
      status_next[ST_INTACT]   = ~(crc_err | align_err | overrun_reg | missed);
      status_next[ST_RX_OFF]   = cfg_reg[CFG_LISTEN];
      status_next[ST_DEFER]    = car_s2_reg;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         car_s1_reg <= 1'b0;
         car_s2_reg <= 1'b0;
      end else begin
         car_s1_reg <= carrier_or_collision;
         car_s2_reg <= car_s1_reg;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg      <= STATUS_RESET;
         store_reg       <= 1'b0;
         status_wr_reg   <= 1'b0;
         status_byte_reg <= 8'h00;
         inc_reg         <= 3'b000;
         frame_abort_reg <= 1'b0;
      end else begin
         status_wr_reg   <= 1'b0;
         inc_reg         <= 3'b000;
         frame_abort_reg <= fifo_overflow & (in_frame_reg | frame_start);
         if (frame_start) begin
            status_reg <= STATUS_RESET;
            store_reg  <= 1'b0;
         end else if (frame_end && in_frame_reg) begin
            status_reg      <= status_next;
            store_reg       <= keep;
            status_wr_reg   <= keep;
            status_byte_reg <= status_next;
            // alignment errors also count in the crc tally
            inc_reg <= {missed, {align_err, crc_err} & {2{~overrun_reg}}};
         end else begin
            status_reg[ST_RX_OFF] <= cfg_reg[CFG_LISTEN];
            status_reg[ST_DEFER]  <= car_s2_reg;
         end
      end
   end
   // local copies of the tallies; saturate rather than wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc_tally_reg    <= 8'h00;
         align_tally_reg  <= 8'h00;
         missed_tally_reg <= 8'h00;
      end else begin
         if (inc_reg[0] && crc_tally_reg != 8'hff)    crc_tally_reg    <= crc_tally_reg + 8'h01;
         if (inc_reg[1] && align_tally_reg != 8'hff)  align_tally_reg  <= align_tally_reg + 8'h01;
         if (inc_reg[2] && missed_tally_reg != 8'hff) missed_tally_reg <= missed_tally_reg + 8'h01;
      end
   end
   assign frame_abort       = frame_abort_reg;
   assign frame_store       = store_reg;
   assign status_write      = status_wr_reg;
   assign status_byte       = status_byte_reg;
   assign crc_error_inc     = inc_reg[0];
   assign align_error_inc   = inc_reg[1];
   assign missed_packet_inc = inc_reg[2];
   property p_cfg_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_cfg |=> cfg_reg == ($past(s_axi_wdata[7:0]) & CFG_MASK);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
   property p_status_clear;
      @(posedge aclk) disable iff (!aresetn)
      frame_start |=> status_reg == STATUS_RESET;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");
   property p_intact;
      @(posedge aclk) disable iff (!aresetn)
      status_wr_reg |-> status_byte_reg[ST_INTACT] == ~|status_byte_reg[ST_MISSED:ST_CRC];
   endproperty
   a_intact: assert property (p_intact) else $error("intact flag wrong");
   property p_no_align_only;
      @(posedge aclk) disable iff (!aresetn)
      status_reg[ST_ALIGN] |-> status_reg[ST_CRC];
   endproperty
   a_no_align_only: assert property (p_no_align_only) else $error("align without crc");
   property p_listen_no_store;
      @(posedge aclk) disable iff (!aresetn)
      (frame_end && in_frame_reg && cfg_reg[CFG_LISTEN]) |=> !status_write && !frame_store;
   endproperty
   a_listen_no_store: assert property (p_listen_no_store) else $error("stored in listen");
   property p_err_drop;
      @(posedge aclk) disable iff (!aresetn)
      (frame_end && in_frame_reg && crc_bad && !cfg_reg[CFG_SAVE_ERR]) |=> !status_write;
   endproperty
   a_err_drop: assert property (p_err_drop) else $error("errored frame kept");
   property p_runt;
      @(posedge aclk) disable iff (!aresetn)
      (frame_end && in_frame_reg && frame_length < MIN_RUNT_BYTES) |=> !frame_store;
   endproperty
   a_runt: assert property (p_runt) else $error("tiny frame kept");
   property p_unmatched;
      @(posedge aclk) disable iff (!aresetn)
      (frame_end && in_frame_reg && !addr_ok) |=> !missed_packet_inc && !status_write;
   endproperty
   a_unmatched: assert property (p_unmatched) else $error("unmatched frame acted on");
   property p_rx_off;
      @(posedge aclk) disable iff (!aresetn)
      (!frame_start && !frame_end) |=> status_reg[ST_RX_OFF] == $past(cfg_reg[CFG_LISTEN]);
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("receiver off flag stale");
endmodule : receive_filter_and_status

// ===== design/rx_filter_pkg.sv
// constants for the receive acceptance filter and packet status block
package rx_filter_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_RX_CFG_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_STATION_LO    = 8'h40;
   localparam logic [7:0] ADDR_STATION_HI    = 8'h44;
   localparam logic [7:0] ADDR_HASH_LO       = 8'h48;
   localparam logic [7:0] ADDR_HASH_HI       = 8'h4c;
   localparam logic [7:0] ADDR_RING_PAGES    = 8'h50;
   localparam logic [7:0] ADDR_TALLIES       = 8'h54;
   // config bit positions
   localparam int CFG_SAVE_ERR  = 0;
   localparam int CFG_RUNT      = 1;
   localparam int CFG_BCAST     = 2;
   localparam int CFG_GROUP     = 3;
   localparam int CFG_ALL_UNI   = 4;
   localparam int CFG_LISTEN    = 5;
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] CFG_MASK   = 8'h3f;
   // status bit positions
   localparam int ST_INTACT   = 0;
   localparam int ST_CRC      = 1;
   localparam int ST_ALIGN    = 2;
   localparam int ST_OVERRUN  = 3;
   localparam int ST_MISSED   = 4;
   localparam int ST_GROUP    = 5;
   localparam int ST_RX_OFF   = 6;
   localparam int ST_DEFER    = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // frame length limits in bytes; dribble limit in bits
   localparam logic [15:0] MIN_FRAME_BYTES = 16'd64;
   localparam logic [15:0] MIN_RUNT_BYTES  = 16'd8;
   localparam logic [2:0]  DRIBBLE_LIMIT   = 3'd6;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rx_filter_pkg

// ===== test/rx_frame_source.sv
// network receive datapath model feeding frames into the filter
`timescale 1ns/1ns
module rx_frame_source (
   input  wire logic        aclk,
   output      logic        frame_start,
   output      logic        dest_byte_valid,
   output      logic [7:0]  dest_byte,
   output      logic [5:0]  dest_hash_index,
   output      logic        frame_end,
   output      logic [15:0] frame_length,
   output      logic        crc_bad,
   output      logic [2:0]  dribble_bits,
   output      logic        fifo_overflow,
   output      logic        no_rx_buffers
);
   initial begin
      frame_start = 1'b0;
      dest_byte_valid = 1'b0;
      dest_byte = 8'h00;
      dest_hash_index = 6'h00;
      frame_end = 1'b0;
      frame_length = 16'h0000;
      crc_bad = 1'b0;
      dribble_bits = 3'h0;
      fifo_overflow = 1'b0;
      no_rx_buffers = 1'b0;
   end
   // start, six address bytes back to back, end; returns at the edge sampling the end
   task automatic send(input logic [47:0] d, input logic [5:0] h, input logic [15:0] len,
                       input logic c, input logic [2:0] dr, input logic nb, input logic ov);
      frame_start <= 1'b1;
      @(posedge aclk);
      frame_start <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         dest_byte_valid <= 1'b1;
         dest_byte       <= d[8*k +: 8];
         dest_hash_index <= h;
         fifo_overflow   <= ov && (k == 3);
         @(posedge aclk);
      end
      dest_byte_valid <= 1'b0;
      dest_byte       <= ~d[47:40];
      fifo_overflow   <= 1'b0;
      frame_end       <= 1'b1;
      frame_length    <= len;
      crc_bad         <= c;
      dribble_bits    <= dr;
      no_rx_buffers   <= nb;
      @(posedge aclk);
      // idle lines flip so a stale value is never mistaken for a fresh one
      frame_end       <= 1'b0;
      frame_length    <= ~len;
      crc_bad         <= ~c;
      dribble_bits    <= ~dr;
      no_rx_buffers   <= ~nb;
   endtask : send
endmodule : rx_frame_source

// ===== test/receive_filter_and_status_test.sv
// self-checking bench for the receive filter and packet status block
`timescale 1ns/1ns
module receive_filter_and_status_test;
   import rx_filter_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, dest_byte, status_byte;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [5:0]  dest_hash_index;
   logic [15:0] frame_length;
   logic [2:0]  dribble_bits;
   logic frame_start, dest_byte_valid, frame_end, crc_bad, fifo_overflow, no_rx_buffers;
   logic carrier_or_collision, frame_abort, frame_store, status_write, abort_seen;
   logic crc_error_inc, align_error_inc, missed_packet_inc;
   int   bad_count, comparisons;
   localparam logic [47:0] STN = 48'h554433221102;
   localparam logic [47:0] OTH = 48'h554433221104;
   localparam logic [47:0] BC  = 48'hffffffffffff;
   localparam logic [47:0] GRP = 48'h5e0000000001;

   receive_filter_and_status uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_start,
      .dest_byte_valid, .dest_byte, .dest_hash_index, .frame_end, .frame_length, .crc_bad,
      .dribble_bits, .fifo_overflow, .no_rx_buffers, .carrier_or_collision, .frame_abort,
      .frame_store, .status_write, .status_byte, .crc_error_inc, .align_error_inc,
      .missed_packet_inc);
   rx_frame_source src (.aclk, .frame_start, .dest_byte_valid, .dest_byte, .dest_hash_index,
      .frame_end, .frame_length, .crc_bad, .dribble_bits, .fifo_overflow, .no_rx_buffers);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // abort pulse is one cycle wide and mid-frame, so latch it per frame
   always @(posedge aclk) begin
      if (frame_start) abort_seen <= 1'b0;
      else if (frame_abort) abort_seen <= 1'b1;
   end

   task automatic summarize();
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      s_axi_bready  <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready  <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready  <= 1'b0;
   endtask : axi_rd

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, r);
      check(32'(r), 32'(RESP_OKAY));
   endtask : wr_ok

   task automatic cfg(input logic [7:0] v);
      wr_ok(ADDR_RX_CFG_STATUS, {24'h0, v});
   endtask : cfg

   // es of ff skips the status register read-back; inc is {crc, align, missed}
   task automatic frm(input logic [47:0] d, input logic [5:0] h, input logic [15:0] len,
                      input logic c, input logic [2:0] dr, input logic nb, input logic ov,
                      input logic st, input logic [7:0] es, input logic [2:0] inc);
      src.send(d, h, len, c, dr, nb, ov);
      #1;
      check(32'(frame_store), 32'(st));
      check(32'(status_write), 32'(st));
      check(32'({crc_error_inc, align_error_inc, missed_packet_inc}), 32'(inc));
      check(32'(abort_seen), 32'(ov));
      if (st) check(32'(status_byte), 32'(es));
      @(posedge aclk);
      if (es !== 8'hff) begin
         axi_rd(ADDR_RX_CFG_STATUS, rd, r);
         check(rd, {24'h0, es});
      end
   endtask : frm

   initial begin
      #100000;
      bad_count++;
      summarize();
   end

   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      carrier_or_collision = 1'b0;
      bad_count = 0;
      comparisons = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wr_ok(ADDR_STATION_LO, 32'h33221102);
      wr_ok(ADDR_STATION_HI, 32'h00005544);
      wr_ok(ADDR_HASH_LO, 32'h00000020);
      wr_ok(ADDR_HASH_HI, 32'h00000000);
      cfg(8'h00);
      frm(STN, 6'd0, 16'd64, 0, 3'd0, 0, 0, 1, 8'h01, 3'b000);
      frm(OTH, 6'd0, 16'd64, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h10);
      frm(OTH, 6'd0, 16'd64, 0, 3'd0, 0, 0, 1, 8'h01, 3'b000);
      cfg(8'h00);
      frm(STN, 6'd0, 16'd63, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h02);
      frm(STN, 6'd0, 16'd8, 0, 3'd0, 0, 0, 1, 8'h01, 3'b000);
      frm(STN, 6'd0, 16'd7, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h00);
      frm(STN, 6'd0, 16'd64, 1, 3'd0, 0, 0, 0, 8'hff, 3'b100);
      cfg(8'h01);
      frm(STN, 6'd0, 16'd64, 1, 3'd0, 0, 0, 1, 8'h02, 3'b100);
      frm(STN, 6'd0, 16'd64, 1, 3'd6, 0, 0, 1, 8'h06, 3'b110);
      frm(STN, 6'd0, 16'd64, 1, 3'd5, 0, 0, 1, 8'h02, 3'b100);
      frm(STN, 6'd0, 16'd64, 0, 3'd6, 0, 0, 1, 8'h01, 3'b000);
      cfg(8'h00);
      frm(BC, 6'd0, 16'd64, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h04);
      frm(BC, 6'd0, 16'd64, 0, 3'd0, 0, 0, 1, 8'h21, 3'b000);
      frm(STN, 6'd0, 16'd64, 0, 3'd0, 0, 0, 1, 8'h01, 3'b000);
      cfg(8'h08);
      frm(GRP, 6'd5, 16'd64, 0, 3'd0, 0, 0, 1, 8'h21, 3'b000);
      frm(GRP, 6'd6, 16'd64, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h00);
      frm(GRP, 6'd5, 16'd64, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h20);
      frm(STN, 6'd0, 16'd64, 0, 3'd0, 0, 0, 0, 8'h50, 3'b001);
      frm(OTH, 6'd0, 16'd64, 0, 3'd0, 0, 0, 0, 8'hff, 3'b000);
      cfg(8'h00);
      frm(STN, 6'd0, 16'd64, 0, 3'd0, 1, 0, 0, 8'h10, 3'b001);
      frm(STN, 6'd0, 16'd64, 0, 3'd0, 0, 1, 0, 8'h08, 3'b000);
      carrier_or_collision <= 1'b1;
      repeat (5) @(posedge aclk);
      frm(STN, 6'd0, 16'd64, 0, 3'd0, 0, 0, 1, 8'h81, 3'b000);
      carrier_or_collision <= 1'b0;
      wr_ok(ADDR_RING_PAGES, 32'h00332211);
      axi_rd(ADDR_RING_PAGES, rd, r);
      check(rd, 32'h00000033);
      axi_rd(8'h80, rd, r);
      check(rd, 32'h0);
      check(32'(r), 32'(RESP_SLVERR));
      axi_wr(8'h84, 32'h0, r);
      check(32'(r), 32'(RESP_SLVERR));
      summarize();
   end
endmodule : receive_filter_and_status_test
